// ---- logic/dtcu_top.sv ----
`timescale 1ns/100ps
module dtcu_top (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] TIMER_MODE_REG,
  input wire logic T0_SPEED_SEL,
  input wire logic T1_SPEED_SEL,
  input wire logic T0_RUN,
  input wire logic T1_RUN,
  input wire logic EXT_IRQ_PIN_ZERO,
  input wire logic EXT_IRQ_PIN_ONE,
  input wire logic COUNT_PIN_ZERO,
  input wire logic COUNT_PIN_ONE,
  input wire logic T0_TOGGLE_ENABLE,
  input wire logic T1_TOGGLE_ENABLE,
  input wire logic [7:0] WR_DATA,
  input wire logic T0_WR_LOW,
  input wire logic T0_WR_HIGH,
  input wire logic T1_WR_LOW,
  input wire logic T1_WR_HIGH,
  input wire logic T0_OVF_CLEAR,
  input wire logic T1_OVF_CLEAR,
  output logic [7:0] T0_COUNT_LOW,
  output logic [7:0] T0_COUNT_HIGH,
  output logic [7:0] T1_COUNT_LOW,
  output logic [7:0] T1_COUNT_HIGH,
  output logic T0_OVERFLOW,
  output logic T1_OVERFLOW,
  output logic COUNT_PIN_ZERO_OUT,
  output logic COUNT_PIN_ONE_OUT
);
  import dtcu_pkg::*;

  // ****************************************
  // Machine cycle phase and time bases
  // ****************************************
  logic [1:0] phase_reg;
  logic [3:0] div0_reg;
  logic [3:0] div1_reg;
  logic c3;
  logic c4;
  logic tick0;
  logic tick1;

  function automatic logic [3:0] div_step(input logic [3:0] cnt,
                                          input logic fast);
    logic [3:0] top;
    // The divider steps once per machine cycle, so the clock ratio is
    // scaled down by the number of phases in a machine cycle.
    top = fast ? DIV_FAST : DIV_SLOW;
    top = top / 4'(PHASES_PER_CYCLE);
    div_step = (cnt >= top - 4'h1) ? 4'h0 : cnt + 4'h1;
  endfunction

  assign c3 = (phase_reg == PHASE_C3);
  assign c4 = (phase_reg == PHASE_C4);
  assign tick0 = c3 && (div0_reg == 4'h0);
  assign tick1 = c3 && (div1_reg == 4'h0);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      phase_reg <= 2'h0;
      div0_reg <= 4'h0;
      div1_reg <= 4'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
      if (c3) begin
        div0_reg <= div_step(div0_reg, T0_SPEED_SEL);
        div1_reg <= div_step(div1_reg, T1_SPEED_SEL);
      end
    end
  end

  // ****************************************
  // Mode register fields
  // ****************************************
  logic [1:0] mode0;
  logic [1:0] mode1;
  logic func0;
  logic func1;
  logic gate0;
  logic gate1;
  logic split0;

  assign mode0 = {TIMER_MODE_REG[T0_MODE_HI_BIT],
                  TIMER_MODE_REG[T0_MODE_LO_BIT]};
  assign mode1 = {TIMER_MODE_REG[T1_MODE_HI_BIT],
                  TIMER_MODE_REG[T1_MODE_LO_BIT]};
  assign func0 = TIMER_MODE_REG[T0_FUNC_BIT];
  assign func1 = TIMER_MODE_REG[T1_FUNC_BIT];
  assign gate0 = TIMER_MODE_REG[T0_GATE_BIT];
  assign gate1 = TIMER_MODE_REG[T1_GATE_BIT];
  assign split0 = (mode0 == 2'(DTCU_MODE_SPLIT));

  // ****************************************
  // Count pin edge detectors
  // ****************************************
  logic fall0;
  logic fall1;

  dtcu_edge u_edge0 (
    .CLK(CLK),
    .RST(RST),
    .sample_en(c4),
    .pin_in(COUNT_PIN_ZERO),
    .fall_seen(fall0)
  );

  dtcu_edge u_edge1 (
    .CLK(CLK),
    .RST(RST),
    .sample_en(c4),
    .pin_in(COUNT_PIN_ONE),
    .fall_seen(fall1)
  );

  // ****************************************
  // Count enables
  // ****************************************
  logic qual0;
  logic qual1;
  logic src0;
  logic src1;
  logic inc0_low;
  logic inc0_high;
  logic inc1_low;
  logic run1_eff;

  assign qual0 = T0_RUN && (!gate0 || EXT_IRQ_PIN_ZERO);
  // run bit lent to timer 0
  assign run1_eff = split0 ? 1'b1 : T1_RUN;
  assign qual1 = run1_eff && (!gate1 || EXT_IRQ_PIN_ONE);
  assign src0 = func0 ? (c3 && fall0) : tick0;
  assign src1 = func1 ? (c3 && fall1) : tick1;
  assign inc0_low = qual0 && src0;
  assign inc0_high = split0 && T1_RUN && tick0;
  assign inc1_low = qual1 && src1 && (mode1 != 2'(DTCU_MODE_SPLIT));

  // ****************************************
  // Counters
  // ****************************************
  logic wrap0_low;
  logic wrap0_high;
  logic wrap1;

  dtcu_count u_count0 (
    .CLK(CLK),
    .RST(RST),
    .mode(mode0),
    .inc_low(inc0_low),
    .inc_high(inc0_high),
    .wr_low(T0_WR_LOW),
    .wr_high(T0_WR_HIGH),
    .wr_data(WR_DATA),
    .low_q(T0_COUNT_LOW),
    .high_q(T0_COUNT_HIGH),
    .low_wrap(wrap0_low),
    .high_wrap(wrap0_high)
  );

  dtcu_count u_count1 (
    .CLK(CLK),
    .RST(RST),
    .mode(mode1),
    .inc_low(inc1_low),
    .inc_high(1'b0),
    .wr_low(T1_WR_LOW),
    .wr_high(T1_WR_HIGH),
    .wr_data(WR_DATA),
    .low_q(T1_COUNT_LOW),
    .high_q(T1_COUNT_HIGH),
    .low_wrap(wrap1),
    .high_wrap()
  );

  // ****************************************
  // Overflow flags and toggle outputs
  // ****************************************
  logic set0;
  logic set1;
  logic tf0_reg;
  logic tf1_reg;
  logic tog0_reg;
  logic tog1_reg;

  assign set0 = wrap0_low;
  assign set1 = split0 ? wrap0_high : wrap1;

  // The set wins over a clear arriving in the same cycle.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tf0_reg <= 1'b0;
      tf1_reg <= 1'b0;
    end else begin
      tf0_reg <= set0 | (tf0_reg & ~T0_OVF_CLEAR);
      tf1_reg <= set1 | (tf1_reg & ~T1_OVF_CLEAR);
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tog0_reg <= 1'b1;
      tog1_reg <= 1'b1;
    end else begin
      if (T0_TOGGLE_ENABLE && !func0 && wrap0_low) begin
        tog0_reg <= ~tog0_reg;
      end
      if (T1_TOGGLE_ENABLE && !func1 && wrap1) begin
        tog1_reg <= ~tog1_reg;
      end
    end
  end

  assign T0_OVERFLOW = tf0_reg;
  assign T1_OVERFLOW = tf1_reg;
  assign COUNT_PIN_ZERO_OUT = tog0_reg;
  assign COUNT_PIN_ONE_OUT = tog1_reg;
endmodule

// ---- logic/dtcu_pkg.sv ----
package dtcu_pkg;
  // ****************************************
  // Machine cycle phases and prescale
  // ****************************************
  localparam int unsigned PHASES_PER_CYCLE = 4;
  localparam logic [1:0] PHASE_C3 = 2'h2;
  localparam logic [1:0] PHASE_C4 = 2'h3;
  localparam logic [3:0] DIV_SLOW = 4'hc;
  localparam logic [3:0] DIV_FAST = 4'h4;
  localparam logic SPEED_RESET = 1'b0;
  // ****************************************
  // Timer mode register field positions
  // ****************************************
  localparam int unsigned T0_MODE_LO_BIT = 0;
  localparam int unsigned T0_MODE_HI_BIT = 1;
  localparam int unsigned T0_FUNC_BIT = 2;
  localparam int unsigned T0_GATE_BIT = 3;
  localparam int unsigned T1_MODE_LO_BIT = 4;
  localparam int unsigned T1_MODE_HI_BIT = 5;
  localparam int unsigned T1_FUNC_BIT = 6;
  localparam int unsigned T1_GATE_BIT = 7;
  localparam logic [7:0] MODE_REG_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  // ****************************************
  // Counter modes
  // ****************************************
  typedef enum logic [1:0] {
    DTCU_MODE_13BIT = 2'b00,
    DTCU_MODE_16BIT = 2'b01,
    DTCU_MODE_RELOAD = 2'b10,
    DTCU_MODE_SPLIT = 2'b11
  } dtcu_mode_t;
endpackage

// ---- logic/dtcu_edge.sv ----
`timescale 1ns/100ps
module dtcu_edge (
  input wire logic CLK,
  input wire logic RST,
  input wire logic sample_en,
  input wire logic pin_in,
  output logic fall_seen
);
  import dtcu_pkg::*;
  logic cur_reg;
  logic seen_reg;
  logic seen_next;
  assign seen_next = cur_reg & ~pin_in;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cur_reg <= 1'b1;
      seen_reg <= 1'b0;
    end else if (sample_en) begin
      cur_reg <= pin_in;
      seen_reg <= seen_next;
    end
  end
  // Held for a whole machine cycle so C3 of the next cycle sees it.
  assign fall_seen = seen_reg;
endmodule

// ---- logic/dtcu_count.sv ----
`timescale 1ns/100ps
module dtcu_count (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [1:0] mode,
  input wire logic inc_low,
  input wire logic inc_high,
  input wire logic wr_low,
  input wire logic wr_high,
  input wire logic [7:0] wr_data,
  output logic [7:0] low_q,
  output logic [7:0] high_q,
  output logic low_wrap,
  output logic high_wrap
);
  import dtcu_pkg::*;
  logic [7:0] low_reg;
  logic [7:0] high_reg;
  logic [7:0] low_next;
  logic [7:0] high_next;
  logic low_full;
  logic [4:0] low5;
  assign low5 = low_reg[4:0];
  assign low_full = (mode == 2'(DTCU_MODE_13BIT)) ? (low5 == 5'h1f) :
                    (low_reg == 8'hff);
  always_comb begin
    low_next = low_reg;
    high_next = high_reg;
    low_wrap = 1'b0;
    high_wrap = 1'b0;
    case (mode)
      2'(DTCU_MODE_13BIT), 2'(DTCU_MODE_16BIT): begin
        if (inc_low) begin
          if (mode == 2'(DTCU_MODE_13BIT)) begin
            low_next = {low_reg[7:5], low5 + 5'h01};
          end else begin
            low_next = low_reg + 8'h01;
          end
          if (low_full) begin
            high_next = high_reg + 8'h01;
            low_wrap = (high_reg == 8'hff);
          end
        end
      end
      2'(DTCU_MODE_RELOAD): begin
        if (inc_low) begin
          low_next = low_full ? high_reg : low_reg + 8'h01;
          low_wrap = low_full;
        end
      end
      default: begin
        if (inc_low) begin
          low_next = low_reg + 8'h01;
          low_wrap = low_full;
        end
        if (inc_high) begin
          high_next = high_reg + 8'h01;
          high_wrap = (high_reg == 8'hff);
        end
      end
    endcase
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      low_reg <= COUNT_RESET;
      high_reg <= COUNT_RESET;
    end else begin
      low_reg <= wr_low ? wr_data : low_next;
      high_reg <= wr_high ? wr_data : high_next;
    end
  end
  assign low_q = low_reg;
  assign high_q = high_reg;
endmodule

// ---- testbench/dtcu_assertions.sv ----
`timescale 1ns/100ps
module dtcu_checker (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] TIMER_MODE_REG,
  input wire logic T0_RUN,
  input wire logic EXT_IRQ_PIN_ZERO,
  input wire logic T0_TOGGLE_ENABLE,
  input wire logic [7:0] WR_DATA,
  input wire logic T0_WR_LOW,
  input wire logic T0_WR_HIGH,
  input wire logic T1_WR_LOW,
  input wire logic T1_WR_HIGH,
  input wire logic T1_OVF_CLEAR,
  input wire logic [7:0] T0_COUNT_LOW,
  input wire logic [7:0] T0_COUNT_HIGH,
  input wire logic [7:0] T1_COUNT_LOW,
  input wire logic [7:0] T1_COUNT_HIGH,
  input wire logic T0_OVERFLOW,
  input wire logic T1_OVERFLOW,
  input wire logic COUNT_PIN_ZERO_OUT
);
  import dtcu_pkg::*;
  // ****************************************
  // Phase tracking and properties
  // ****************************************
  logic [1:0] ph_reg;
  logic c3;
  logic t0_wr;
  logic t0_off;
  assign c3 = (ph_reg == PHASE_C3);
  assign t0_wr = T0_WR_LOW | T0_WR_HIGH;
  // The gate pin only matters while the gate bit is set.
  assign t0_off = !T0_RUN | (TIMER_MODE_REG[3] & !EXT_IRQ_PIN_ZERO);
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ph_reg <= 2'h0;
    end else begin
      ph_reg <= ph_reg + 2'h1;
    end
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  chk_count_on_c3: assert property (
    !$past(t0_wr) && !$past(c3) |-> $stable({T0_COUNT_HIGH, T0_COUNT_LOW}))
    else $error("t0 count moved off its phase");
  chk_low_write: assert property (
    T0_WR_LOW |=> T0_COUNT_LOW == $past(WR_DATA))
    else $error("t0 low write lost");
  chk_flag_phase: assert property (
    $rose(T0_OVERFLOW) |-> $past(c3))
    else $error("t0 flag set off phase");
  chk_flag_clear: assert property (
    T1_OVF_CLEAR && !c3 |=> !T1_OVERFLOW)
    else $error("t1 flag not cleared");
  chk_toggle_cause: assert property (
    $changed(COUNT_PIN_ZERO_OUT) |->
    $past(c3) && $past(T0_TOGGLE_ENABLE) && !$past(TIMER_MODE_REG[2]))
    else $error("pin zero toggled without cause");
  chk_reload_low: assert property (
    $past(TIMER_MODE_REG[1:0]) == 2'h2 && $past(T0_COUNT_LOW) == 8'hff &&
    T0_COUNT_LOW != 8'hff && !$past(t0_wr)
    |-> T0_COUNT_LOW == T0_COUNT_HIGH && T0_OVERFLOW)
    else $error("t0 reload wrong");
  chk_t1_frozen: assert property (
    TIMER_MODE_REG[5:4] == 2'h3 && !T1_WR_LOW && !T1_WR_HIGH
    |=> $stable({T1_COUNT_HIGH, T1_COUNT_LOW}))
    else $error("t1 counted while frozen");
  chk_run_gate: assert property (
    (t0_off && TIMER_MODE_REG[1:0] != 2'h3 && !t0_wr) [*2]
    |=> $stable({T0_COUNT_HIGH, T0_COUNT_LOW}))
    else $error("t0 counted while disabled");
  cover property ($rose(T0_OVERFLOW));
  cover property ($rose(T1_OVERFLOW));
  cover property ($fell(COUNT_PIN_ZERO_OUT));
endmodule
bind dtcu_top dtcu_checker chk_i (.*);

// ---- testbench/dtcu_pins.sv ----
`timescale 1ns/100ps
module dtcu_pins (
  input wire logic CLK,
  output logic COUNT_PIN_ZERO,
  output logic COUNT_PIN_ONE,
  output logic EXT_IRQ_PIN_ZERO,
  output logic EXT_IRQ_PIN_ONE
);
  // ****************************************
  // External count and gate pins
  // ****************************************
  logic [1:0] cnt_lvl = 2'h3;
  logic [1:0] irq_lvl = 2'h0;
  assign COUNT_PIN_ZERO = cnt_lvl[0];
  assign COUNT_PIN_ONE = cnt_lvl[1];
  assign EXT_IRQ_PIN_ZERO = irq_lvl[0];
  assign EXT_IRQ_PIN_ONE = irq_lvl[1];
  task automatic set_irq(input logic [1:0] v);
    irq_lvl <= v;
  endtask
  // each level spans at least a machine cycle.
  task automatic edges(input int pin, input int n, input int half);
    int h;
    h = (half < 4) ? 4 : half;
    repeat (n) begin
      @(posedge CLK);
      cnt_lvl[pin] <= 1'b0;
      repeat (h) @(posedge CLK);
      cnt_lvl[pin] <= 1'b1;
      repeat (h - 1) @(posedge CLK);
    end
  endtask
endmodule

// ---- testbench/tb.sv ----
`timescale 1ns/100ps
module tb;
  logic CLK, RST, T0_SPEED_SEL, T1_SPEED_SEL, T0_RUN, T1_RUN;
  logic [7:0] TIMER_MODE_REG, WR_DATA;
  logic EXT_IRQ_PIN_ZERO, EXT_IRQ_PIN_ONE, COUNT_PIN_ZERO, COUNT_PIN_ONE;
  logic T0_TOGGLE_ENABLE, T1_TOGGLE_ENABLE, T0_OVF_CLEAR, T1_OVF_CLEAR;
  logic T0_WR_LOW, T0_WR_HIGH, T1_WR_LOW, T1_WR_HIGH;
  logic [7:0] T0_COUNT_LOW, T0_COUNT_HIGH, T1_COUNT_LOW, T1_COUNT_HIGH;
  logic T0_OVERFLOW, T1_OVERFLOW, COUNT_PIN_ZERO_OUT, COUNT_PIN_ONE_OUT;
  int fails = 0;
  int compares = 0;
  dtcu_top dut (.*);
  dtcu_pins pins (.*);
  // ****************************************
  // Access tasks
  // ****************************************
  task automatic end_of_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic flags(input logic [3:0] exp);
    chk({T0_OVERFLOW, T1_OVERFLOW, COUNT_PIN_ZERO_OUT, COUNT_PIN_ONE_OUT}, exp);
  endtask
  task automatic cfg(input logic [7:0] m, input logic s0, input logic s1);
    @(posedge CLK);
    TIMER_MODE_REG <= m;
    T0_SPEED_SEL <= s0;
    T1_SPEED_SEL <= s1;
    T0_OVF_CLEAR <= 1'b1;
    T1_OVF_CLEAR <= 1'b1;
    @(posedge CLK);
    T0_OVF_CLEAR <= 1'b0;
    T1_OVF_CLEAR <= 1'b0;
  endtask
  task automatic wr(input logic t1, input logic [15:0] v);
    @(posedge CLK);
    WR_DATA <= v[7:0];
    T0_WR_LOW <= !t1;
    T1_WR_LOW <= t1;
    @(posedge CLK);
    WR_DATA <= v[15:8];
    T0_WR_LOW <= 1'b0;
    T1_WR_LOW <= 1'b0;
    T0_WR_HIGH <= !t1;
    T1_WR_HIGH <= t1;
    @(posedge CLK);
    T0_WR_HIGH <= 1'b0;
    T1_WR_HIGH <= 1'b0;
  endtask
  task automatic run(input logic r0, r1, input logic [1:0] g, input int n);
    @(posedge CLK);
    T0_RUN <= r0;
    T1_RUN <= r1;
    pins.set_irq(g);
    repeat (n) @(posedge CLK);
    T0_RUN <= 1'b0;
    T1_RUN <= 1'b0;
    pins.set_irq(2'h0);
    @(posedge CLK);
    #1;
  endtask
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  initial begin
    repeat (3000) @(posedge CLK);
    fails++;
    end_of_test();
  end
  initial begin
    {T0_SPEED_SEL, T1_SPEED_SEL, T0_RUN, T1_RUN} = 4'h0;
    {TIMER_MODE_REG, WR_DATA, T1_TOGGLE_ENABLE} = 17'h0;
    {T0_WR_LOW, T0_WR_HIGH, T1_WR_LOW, T1_WR_HIGH} = 4'h0;
    {T0_OVF_CLEAR, T1_OVF_CLEAR} = 2'h0;
    T0_TOGGLE_ENABLE = 1'b1;
    RST = 1'b1;
    repeat (6) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    #1;
    chk({T0_COUNT_HIGH, T0_COUNT_LOW}, 16'h0000);
    chk({T1_COUNT_HIGH, T1_COUNT_LOW}, 16'h0000);
    flags(4'h3);
    $display("test reset done");
    cfg(8'h11, 1'b1, 1'b0);
    wr(0, 16'hfffe);
    wr(1, 16'h1234);
    run(1, 1, 2'h0, 24);
    chk({T0_COUNT_HIGH, T0_COUNT_LOW}, 16'h0004);
    chk({T1_COUNT_HIGH, T1_COUNT_LOW}, 16'h1236);
    flags(4'h9);
    $display("test wide timer done");
    cfg(8'h00, 1'b1, 1'b1);
    wr(1, 16'hffff);
    run(0, 1, 2'h0, 8);
    chk({T1_COUNT_HIGH, T1_COUNT_LOW}, 16'h00e1);
    flags(4'h5);
    $display("test short timer done");
    cfg(8'h08, 1'b1, 1'b1);
    wr(0, 16'h0000);
    run(1, 0, 2'h0, 40);
    chk({T0_COUNT_HIGH, T0_COUNT_LOW}, 16'h0000);
    run(1, 0, 2'h1, 8);
    chk({T0_COUNT_HIGH, T0_COUNT_LOW}, 16'h0002);
    $display("test gate done");
    cfg(8'h02, 1'b1, 1'b1);
    wr(0, 16'ha5fe);
    run(1, 0, 2'h0, 12);
    chk({T0_COUNT_HIGH, T0_COUNT_LOW}, 16'ha5a6);
    flags(4'hb);
    $display("test reload done");
    cfg(8'h45, 1'b1, 1'b1);
    wr(0, 16'hffff);
    wr(1, 16'h0000);
    fork
      run(1, 1, 2'h0, 100);
      pins.edges(0, 3, 4);
      pins.edges(1, 2, 12);
    join
    chk({T0_COUNT_HIGH, T0_COUNT_LOW}, 16'h0002);
    chk({T1_COUNT_HIGH, T1_COUNT_LOW}, 16'h0002);
    flags(4'hb);
    $display("test counter done");
    wr(1, 16'hfffe);
    wr(0, 16'hfffe);
    cfg(8'h93, 1'b1, 1'b1);
    T1_TOGGLE_ENABLE <= 1'b1;
    run(1, 0, 2'h2, 8);
    chk({T0_COUNT_HIGH, T0_COUNT_LOW}, 16'hff00);
    chk({T1_COUNT_HIGH, T1_COUNT_LOW}, 16'h0000);
    flags(4'h8);
    run(0, 1, 2'h0, 8);
    chk({T0_COUNT_HIGH, T0_COUNT_LOW}, 16'h0100);
    flags(4'hc);
    cfg(8'hb3, 1'b1, 1'b1);
    run(1, 1, 2'h2, 8);
    chk({T0_COUNT_HIGH, T0_COUNT_LOW}, 16'h0302);
    chk({T1_COUNT_HIGH, T1_COUNT_LOW}, 16'h0000);
    $display("test split done");
    end_of_test();
  end
endmodule
